// ===== logic/tamper_channel.sv
// One tamper input channel: synchroniser, sampling gate and trigger decode.
`timescale 1ns/1ps
module tamper_channel
  import tamper_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic pin_in,
  input wire chan_cfg_s cfg,
  input wire logic sample_strobe,
  input wire logic block_supply,
  output logic detect,
  output pull_ctl_s pull
);

  logic meta_ff;
  logic sync_ff;
  logic sampling;
  logic look;

  // ==========================================================================
  // Input synchroniser
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= pin_in; // [R20]
      sync_ff <= meta_ff;
    end
  end

  // ==========================================================================
  // Trigger decode
  // ==========================================================================
  // Sampling only exists for a normally closed switch; normally open is always watched.
  assign sampling = cfg.sample_select & ~cfg.switch_type; // [R13] [R14]
  assign look = sampling ? sample_strobe : 1'b1; // [R13] [R15]

  // Both switch types end with the pin at the chosen level on tamper.
  always_ff @(posedge clk) begin
    if (rst) begin
      detect <= 1'b0;
    end else begin
      detect <= cfg.enable & look & (sync_ff == cfg.trigger_level) // [R03] [R09] [R10] [R11]
        & ~(block_supply & cfg.trigger_level); // [R12]
    end
  end

  // The pull only matters while a normally closed loop is being checked.
  always_ff @(posedge clk) begin
    if (rst) begin
      pull <= '0;
    end else begin
      pull.pull_on <= cfg.enable & ~cfg.switch_type & look;
      pull.pull_strong <= cfg.pull_strength & ~cfg.switch_type; // [R19]
    end
  end

endmodule : tamper_channel

// ===== logic/tamper_detect.sv
// Top of the two-channel tamper detection logic with flags, interrupt and RAM clear.
//
// Overview of operation
// R01: Two channels, each with own flag.
// R02: Per-channel config registers at 14h, 15h.
// R03: Enable activates detection; flag clears only disabled.
// R04: Software disables channel before reconfiguring it.
// R05: Flag read-only, set on event, cleared by disable.
// R06: Interrupt enable drives active-low interrupt on event.
// R07: On battery, interrupt also needs alarm-in-backup.
// R08: Software reads flags before clearing enable.
// R09: Switch type bit: one open, zero closed.
// R10: Trigger level bit: one supply, zero ground.
// R11: Type and level pair give four options.
// R12: External clear interval blocks channel two supply.
// R13: Closed switch: sample at 1Hz or continuous.
// R14: Open switch ignores sample select, continuous.
// R15: Sampling only while oscillator runs.
// R16: Flag sets at once when enabled.
// R17: Interrupt released by read, disable, reset out.
// R18: Internal clear zeroes RAM; invalid until disabled.
// R19: Pull strength bit ignored for open switch.
// R20: Synchronise inputs; 1Hz from oscillator divider.
// R21: Configuration bits zero after power-on reset.
`timescale 1ns/1ps
module tamper_detect
  import tamper_pkg::*;
#(
  parameter int TICKS_PER_SAMPLE = OSC_TICKS_PER_SAMPLE,
  parameter int RAM_DEPTH = USER_RAM_BYTES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic intrusion_input_one,
  input wire logic intrusion_input_two,
  input wire logic osc_tick,
  input wire logic osc_running,
  input wire logic on_battery,
  input wire logic alarm_in_backup_enable,
  input wire logic reset_out_active,
  input wire logic clear_interval_active,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [6:0] ram_addr,
  input wire logic ram_wr,
  input wire logic [7:0] ram_wdata,
  output logic [7:0] ram_rdata,
  output logic irq_n,
  output logic external_clear_out,
  output logic ram_invalid,
  output pull_ctl_s pull_one,
  output pull_ctl_s pull_two
);

  localparam int NCH = 2;
  localparam int DIV_W = $clog2(TICKS_PER_SAMPLE);
  localparam int RAM_AW = $clog2(RAM_DEPTH);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICKS_PER_SAMPLE - 1);
  localparam logic [RAM_AW-1:0] RAM_LAST = RAM_AW'(RAM_DEPTH - 1);

  chan_cfg_s cfg_ff [NCH];
  logic [NCH-1:0] flag_ff;
  logic [NCH-1:0] detect;
  logic [NCH-1:0] new_event;
  logic [NCH-1:0] wr_cfg;
  logic [NCH-1:0] irq_drop;
  logic [NCH-1:0] pins;
  pull_ctl_s pull [NCH];
  logic [DIV_W-1:0] div_ff;
  logic sample_strobe_ff;
  logic irq_set;
  logic irq_clr;
  logic [NCH-1:0] invalid_ff;
  logic [NCH-1:0] wipe_req;
  wipe_state_e wipe_state_ff;
  wipe_state_e nxt_wipe_state;
  logic [RAM_AW-1:0] wipe_addr_ff;
  logic mem_wr;
  logic [RAM_AW-1:0] mem_addr;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata;
  logic ram_rd_invalid_ff;
  logic block_supply;

  assign pins = {intrusion_input_two, intrusion_input_one};

  // ==========================================================================
  // One hertz sampling strobe
  // ==========================================================================
  // The divider halts with the oscillator, so no strobe and no sample is made then.
  always_ff @(posedge clk) begin
    if (rst) begin
      div_ff <= '0;
      sample_strobe_ff <= 1'b0;
    end else begin
      sample_strobe_ff <= 1'b0;
      if (osc_running && osc_tick) begin // [R15]
        if (div_ff == DIV_LAST) begin
          div_ff <= '0;
          sample_strobe_ff <= 1'b1; // [R20]
        end else begin
          div_ff <= div_ff + 1'b1;
        end
      end
    end
  end

  // ==========================================================================
  // Channels and configuration registers
  // ==========================================================================
  // While an external clear runs, channel two must not see a second tamper to supply.
  assign block_supply = clear_interval_active
    & (cfg_ff[0].external_clear | cfg_ff[1].external_clear); // [R12]

  generate
    for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
      assign wr_cfg[ch] = reg_wr && (reg_addr == (ch == 0 ? TAMPER_ONE_CONFIG_ADDR : TAMPER_TWO_CONFIG_ADDR));
      assign irq_drop[ch] = wr_cfg[ch] && cfg_ff[ch].irq_enable && !reg_wdata[CFG_IRQ_ENABLE_BIT];
      assign new_event[ch] = detect[ch] & ~flag_ff[ch];

      always_ff @(posedge clk) begin
        if (rst) begin
          cfg_ff[ch] <= chan_cfg_s'(CONFIG_RESET); // [R21]
        end else if (wr_cfg[ch]) begin
          cfg_ff[ch] <= chan_cfg_s'(reg_wdata); // [R02]
        end
      end

      tamper_channel u_chan (
        .clk(clk),
        .rst(rst),
        .pin_in(pins[ch]),
        .cfg(cfg_ff[ch]),
        .sample_strobe(sample_strobe_ff),
        .block_supply(ch == 1 ? block_supply : 1'b0),
        .detect(detect[ch]),
        .pull(pull[ch])
      );

      // A detection always wins; the flag only falls while the channel is disabled.
      always_ff @(posedge clk) begin
        if (rst) begin
          flag_ff[ch] <= 1'b0;
        end else if (detect[ch]) begin
          flag_ff[ch] <= 1'b1; // [R01] [R05] [R16]
        end else if (!cfg_ff[ch].enable) begin
          flag_ff[ch] <= 1'b0; // [R03] [R05]
        end
      end

      // Each channel keeps the memory deselected from its wipe until it is disabled.
      assign wipe_req[ch] = new_event[ch] & cfg_ff[ch].internal_clear;
      always_ff @(posedge clk) begin
        if (rst) begin
          invalid_ff[ch] <= 1'b0;
        end else if (wipe_req[ch]) begin
          invalid_ff[ch] <= 1'b1; // [R18]
        end else if (!cfg_ff[ch].enable) begin
          invalid_ff[ch] <= 1'b0;
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Interrupt output
  // ==========================================================================
  // In backup the interrupt needs the alarm-in-backup bit as well.
  assign irq_set = ((new_event[0] & cfg_ff[0].irq_enable) | (new_event[1] & cfg_ff[1].irq_enable))
    & (~on_battery | alarm_in_backup_enable); // [R06] [R07]
  assign irq_clr = (reg_rd && reg_addr == EVENT_FLAGS_ADDR) || (|irq_drop) || reset_out_active; // [R17]

  // A new event in the clearing cycle keeps the line asserted.
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_n <= 1'b1;
    end else if (irq_set) begin
      irq_n <= 1'b0; // [R06]
    end else if (irq_clr) begin
      irq_n <= 1'b1; // [R17]
    end
  end

  // ==========================================================================
  // External clear request
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (rst) begin
      external_clear_out <= 1'b0;
    end else begin
      external_clear_out <= (flag_ff[0] & cfg_ff[0].enable & cfg_ff[0].external_clear)
        | (flag_ff[1] & cfg_ff[1].enable & cfg_ff[1].external_clear);
    end
  end

  // ==========================================================================
  // User memory wipe
  // ==========================================================================
  always_comb begin
    nxt_wipe_state = wipe_state_ff;
    case (wipe_state_ff)
      WIPE_IDLE: begin
        if (|wipe_req) begin
          nxt_wipe_state = WIPE_RUN;
        end
      end
      WIPE_RUN: begin
        if (wipe_addr_ff == RAM_LAST) begin
          nxt_wipe_state = WIPE_IDLE;
        end
      end
      default: begin
        nxt_wipe_state = WIPE_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wipe_state_ff <= WIPE_IDLE;
    end else begin
      wipe_state_ff <= nxt_wipe_state;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wipe_addr_ff <= '0;
    end else if (wipe_state_ff == WIPE_RUN) begin
      wipe_addr_ff <= wipe_addr_ff + 1'b1; // [R18]
    end else begin
      wipe_addr_ff <= '0;
    end
  end

  // The wipe owns the memory port; user writes during it are dropped.
  assign mem_wr = (wipe_state_ff == WIPE_RUN) | (ram_wr & ~(|invalid_ff));
  assign mem_addr = (wipe_state_ff == WIPE_RUN) ? wipe_addr_ff : ram_addr[RAM_AW-1:0];
  assign mem_wdata = (wipe_state_ff == WIPE_RUN) ? 8'h00 : ram_wdata; // [R18]

  user_ram #(
    .DEPTH(RAM_DEPTH),
    .AW(RAM_AW)
  ) u_ram (
    .clk(clk),
    .wr(mem_wr),
    .addr(mem_addr),
    .wdata(mem_wdata),
    .rdata(mem_rdata)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      ram_rd_invalid_ff <= 1'b0;
      ram_invalid <= 1'b0;
    end else begin
      ram_rd_invalid_ff <= |invalid_ff;
      ram_invalid <= |invalid_ff;
    end
  end

  // Read data stays one register deep; the invalid marker is aligned to it.
  assign ram_rdata = ram_rd_invalid_ff ? RAM_INVALID_DATA : mem_rdata; // [R18]

  // ==========================================================================
  // Register read port
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        EVENT_FLAGS_ADDR: begin
          reg_rdata <= 8'h00;
          reg_rdata[FLAG_ONE_BIT] <= flag_ff[0]; // [R01]
          reg_rdata[FLAG_TWO_BIT] <= flag_ff[1];
        end
        TAMPER_ONE_CONFIG_ADDR: reg_rdata <= cfg_ff[0];
        TAMPER_TWO_CONFIG_ADDR: reg_rdata <= cfg_ff[1];
        default: reg_rdata <= UNMAPPED_DATA;
      endcase
    end
  end

  // ==========================================================================
  // Pull control
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (rst) begin
      pull_one <= '0;
      pull_two <= '0;
    end else begin
      pull_one <= pull[0];
      pull_two <= pull[1];
    end
  end

endmodule : tamper_detect

// ===== logic/tamper_pkg.sv
// Package with register map, field layout and timing constants of the tamper logic.
package tamper_pkg;

  // ==========================================================================
  // Register offsets
  // ==========================================================================
  localparam logic [7:0] EVENT_FLAGS_ADDR = 8'h0F;
  localparam logic [7:0] TAMPER_ONE_CONFIG_ADDR = 8'h14;
  localparam logic [7:0] TAMPER_TWO_CONFIG_ADDR = 8'h15;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int FLAG_ONE_BIT = 0;
  localparam int FLAG_TWO_BIT = 1;
  localparam int CFG_ENABLE_BIT = 7;
  localparam int CFG_IRQ_ENABLE_BIT = 6;
  localparam int CFG_SWITCH_TYPE_BIT = 5;
  localparam int CFG_TRIGGER_LEVEL_BIT = 4;
  localparam int CFG_SAMPLE_SELECT_BIT = 3;
  localparam int CFG_PULL_STRENGTH_BIT = 2;
  localparam int CFG_INTERNAL_CLEAR_BIT = 1;
  localparam int CFG_EXTERNAL_CLEAR_BIT = 0;

  // ==========================================================================
  // Reset values and fixed answers
  // ==========================================================================
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] RAM_INVALID_DATA = 8'hFF;
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int OSC_FREQ_HZ = 32768;
  localparam int SAMPLE_RATE_HZ = 1;
  localparam int OSC_TICKS_PER_SAMPLE = OSC_FREQ_HZ / SAMPLE_RATE_HZ;
  localparam int USER_RAM_BYTES = 128;

  // Configuration of one channel, bit 7 down to bit 0 of its register.
  typedef struct packed {
    logic enable;
    logic irq_enable;
    logic switch_type;
    logic trigger_level;
    logic sample_select;
    logic pull_strength;
    logic internal_clear;
    logic external_clear;
  } chan_cfg_s;

  // Pull control towards the pad cell of one channel.
  typedef struct packed {
    logic pull_on;
    logic pull_strong;
  } pull_ctl_s;

  typedef enum logic [1:0] {
    WIPE_IDLE = 2'b01,
    WIPE_RUN = 2'b10
  } wipe_state_e;

endpackage : tamper_pkg

// ===== logic/user_ram.sv
// Small single-port user memory with registered read data.
`timescale 1ns/1ps
module user_ram #(
  parameter int DEPTH = 128,
  parameter int AW = 7
) (
  input wire logic clk,
  input wire logic wr,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);

  logic [7:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wr) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule : user_ram

// ===== sim/tamper_asserts.sv
// Checker for the tamper detection top ports.
`timescale 1ns/1ps
module tamper_asserts
  import tamper_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic on_battery,
  input wire logic alarm_in_backup_enable,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] ram_rdata,
  input wire logic irq_n,
  input wire logic ram_invalid
);
  // ====================================================
  // Shadow of both configuration registers
  // ====================================================
  chan_cfg_s c1_ff;
  chan_cfg_s c2_ff;
  logic mapped;
  logic any_ie;
  logic gate;
  logic clr;
  always_ff @(posedge clk) begin
    if (rst) c1_ff <= CONFIG_RESET;
    else if (reg_wr && reg_addr == TAMPER_ONE_CONFIG_ADDR) c1_ff <= reg_wdata;
  end
  always_ff @(posedge clk) begin
    if (rst) c2_ff <= CONFIG_RESET;
    else if (reg_wr && reg_addr == TAMPER_TWO_CONFIG_ADDR) c2_ff <= reg_wdata;
  end
  assign mapped = reg_addr inside {EVENT_FLAGS_ADDR, TAMPER_ONE_CONFIG_ADDR, TAMPER_TWO_CONFIG_ADDR};
  assign any_ie = c1_ff.irq_enable || c2_ff.irq_enable;
  assign gate = !on_battery || alarm_in_backup_enable;
  assign clr = (c1_ff.enable && c1_ff.internal_clear) || (c2_ff.enable && c2_ff.internal_clear);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_unmapped_reads_zero: assert property (reg_rd && !mapped |=> reg_rdata == UNMAPPED_DATA)
    else $error("unmapped read not zero");
  a_flags_upper_zero: assert property (reg_rd && reg_addr == EVENT_FLAGS_ADDR |=> reg_rdata[7:2] == 6'h00)
    else $error("flag read has stray bits");
  a_cfg_one_readback: assert property (reg_rd && reg_addr == TAMPER_ONE_CONFIG_ADDR |=> reg_rdata == $past(c1_ff))
    else $error("config readback differs");
  a_irq_needs_enable: assert property ($fell(irq_n) |-> $past(any_ie))
    else $error("irq without irq enable");
  a_irq_backup_gate: assert property ($fell(irq_n) |-> $past(gate))
    else $error("irq on battery without alarm enable");
  a_ram_blank_read: assert property (ram_invalid && $past(ram_invalid) |-> ram_rdata == RAM_INVALID_DATA)
    else $error("invalid ram not blank");
  a_ram_clear_cause: assert property ($rose(ram_invalid) |-> $past(clr) || $past(clr, 2))
    else $error("ram invalid without clear enable");
  a_ram_invalid_hold: assert property (ram_invalid && c1_ff.enable && c2_ff.enable && !reg_wr |=> ram_invalid)
    else $error("ram invalid dropped while enabled");
endmodule : tamper_asserts

bind tamper_detect tamper_asserts i_tamper_asserts (
  .clk(clk), .rst(rst), .on_battery(on_battery), .alarm_in_backup_enable(alarm_in_backup_enable),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .ram_rdata(ram_rdata), .irq_n(irq_n), .ram_invalid(ram_invalid)
);

// ===== sim/tamper_switch_model.sv
// Model of the two external tamper switches wired to the pins.
`timescale 1ns/1ps
module tamper_switch_model (
  input wire logic [1:0] trip,
  input wire logic [1:0] level,
  output logic pin_one,
  output logic pin_two
);
  // Closing an open switch or opening a closed loop both leave the pin at the trigger
  // level; at rest the pin sits on the opposite rail, never floating.
  assign pin_one = trip[0] ? level[0] : !level[0];
  assign pin_two = trip[1] ? level[1] : !level[1];
endmodule : tamper_switch_model

// ===== sim/tb.sv
// Self-checking bench for the two-channel tamper detection logic.
`timescale 1ns/1ps
module tb
  import tamper_pkg::*;
();
  localparam int TPS = 4;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [1:0] trip = 2'h0;
  logic [1:0] lv = 2'h0;
  logic osc_tick = 1'h0;
  logic osc_running = 1'h0;
  logic on_battery = 1'h0;
  logic abe = 1'h0;
  logic rout = 1'h0;
  logic clr_int = 1'h0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [6:0] ram_addr = 7'h00;
  logic ram_wr = 1'h0;
  logic [7:0] ram_wdata = 8'h00;
  logic [7:0] tick_cnt = 8'h00;
  logic [31:0] seed = 32'h0000005E;
  logic pin1;
  logic pin2;
  logic [7:0] reg_rdata;
  logic [7:0] ram_rdata;
  logic irq_n;
  logic ram_invalid;
  logic ext_clr;
  pull_ctl_s p1;
  pull_ctl_s p2;
  logic [7:0] d;
  logic [7:0] rv;
  chan_cfg_s c;
  int n_errors = 0;
  int compares = 0;

  always #25 clk = ~clk;
  always @(posedge clk) begin
    tick_cnt <= tick_cnt + 8'h01;
    osc_tick <= tick_cnt[0];
  end

  tamper_switch_model i_tamper_switch_model (.trip(trip), .level(lv), .pin_one(pin1), .pin_two(pin2));
  tamper_detect #(.TICKS_PER_SAMPLE(TPS), .RAM_DEPTH(128)) i_tamper_detect (
    .clk(clk), .rst(rst), .intrusion_input_one(pin1), .intrusion_input_two(pin2), .osc_tick(osc_tick),
    .osc_running(osc_running), .on_battery(on_battery), .alarm_in_backup_enable(abe),
    .reset_out_active(rout), .clear_interval_active(clr_int), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ram_addr(ram_addr), .ram_wr(ram_wr),
    .ram_wdata(ram_wdata), .ram_rdata(ram_rdata), .irq_n(irq_n), .external_clear_out(ext_clr),
    .ram_invalid(ram_invalid), .pull_one(p1), .pull_two(p2)
  );

  // ====================================================
  // Expectation helpers and bus tasks
  // ====================================================
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic chan_cfg_s mk(input logic ie, input logic [1:0] m, input logic ss, input logic [1:0] cl);
    return '{1'h1, ie, m[1], m[0], ss, 1'h0, cl[1], cl[0]};
  endfunction : mk
  function automatic logic [7:0] cfg_a(input int ch);
    return (ch == 1) ? TAMPER_TWO_CONFIG_ADDR : TAMPER_ONE_CONFIG_ADDR;
  endfunction : cfg_a
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'h1;
    @(posedge clk) reg_wr <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk) reg_rd <= 1'h0;
    @(negedge clk) v = reg_rdata;
  endtask : rd
  // Detection latency depends on the mode, so waits poll the output under a bound.
  task automatic wait_for(input bit ram);
    int i;
    for (i = 0; i < 60; i++) begin
      @(negedge clk);
      if (ram ? ram_invalid === 1'h1 : irq_n === 1'h0) break;
    end
    if (i == 60) begin
      n_errors++;
      $display("[FAIL] wait expected 1 seen 0");
      complete_run();
    end
  endtask : wait_for

  // ====================================================
  // Scenarios
  // ====================================================
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    for (int ch = 0; ch < 2; ch++) begin
      rd(cfg_a(ch), d);
      check("cfg reset", d, CONFIG_RESET);
    end
    rv = 8'(rnd());
    rd(8'h20 | rv, d);
    check("unmapped", d, UNMAPPED_DATA);
    wr(TAMPER_TWO_CONFIG_ADDR, rv & 8'h7F);
    rd(TAMPER_TWO_CONFIG_ADDR, d);
    check("cfg two", d, rv & 8'h7F);
    wr(TAMPER_TWO_CONFIG_ADDR, 8'h00);
    $display("test reset done");
    for (int m = 0; m < 4; m++) begin
      for (int ch = 0; ch < 2; ch++) begin
        rv = 8'(rnd());
        @(posedge clk) lv[ch] <= m[0];
        c = mk(1'h1, m[1:0], m[1] & rv[0], 2'h0);
        wr(cfg_a(ch), c);
        repeat (12) @(posedge clk);
        rd(EVENT_FLAGS_ADDR, d);
        check("idle flags", d, 8'h00);
        @(posedge clk) trip[ch] <= 1'h1;
        wait_for(1'b0);
        rd(EVENT_FLAGS_ADDR, d);
        check("flags", d, 8'h01 << ch);
        check("irq after read", 8'(irq_n), 8'h01);
        wr(EVENT_FLAGS_ADDR, 8'h00);
        rd(EVENT_FLAGS_ADDR, d);
        check("flag read only", d, 8'h01 << ch);
        @(posedge clk) trip[ch] <= 1'h0;
        wr(cfg_a(ch), 8'h00);
        // The disable still needs the detect stage and the flag register before the flag reads as cleared.
        repeat (2) @(posedge clk);
        rd(EVENT_FLAGS_ADDR, d);
        check("flag cleared", d, 8'h00);
      end
    end
    $display("test modes done");
    @(posedge clk) lv <= 2'h0;
    @(posedge clk) on_battery <= 1'h1;
    for (int ch = 0; ch < 2; ch++) begin
      @(posedge clk) abe <= ch[0];
      c = mk(1'h1, 2'h2, 1'h0, 2'h0);
      wr(cfg_a(ch), c);
      @(posedge clk) trip[ch] <= 1'h1;
      repeat (12) @(posedge clk);
      @(negedge clk);
      check("irq backup", 8'(irq_n), (ch == 0) ? 8'h01 : 8'h00);
      wr(cfg_a(ch), c & 8'hBF);
      @(negedge clk);
      check("irq ie drop", 8'(irq_n), 8'h01);
      rd(EVENT_FLAGS_ADDR, d);
      check("flags backup", d, 8'h01 << ch);
      @(posedge clk) trip[ch] <= 1'h0;
      wr(cfg_a(ch), 8'h00);
    end
    @(posedge clk) on_battery <= 1'h0;
    wr(TAMPER_ONE_CONFIG_ADDR, 8'h60);
    @(posedge clk) trip[0] <= 1'h1;
    repeat (12) @(posedge clk);
    rd(EVENT_FLAGS_ADDR, d);
    check("disabled", d, 8'h00);
    @(posedge clk) trip[0] <= 1'h0;
    wr(TAMPER_ONE_CONFIG_ADDR, 8'h00);
    $display("test battery done");
    @(posedge clk) lv <= 2'h3;
    wr(TAMPER_ONE_CONFIG_ADDR, mk(1'h1, 2'h1, 1'h1, 2'h0));
    @(posedge clk) trip[0] <= 1'h1;
    repeat (40) @(posedge clk);
    rd(EVENT_FLAGS_ADDR, d);
    check("osc stopped", d, 8'h00);
    @(posedge clk) osc_running <= 1'h1;
    wait_for(1'b0);
    @(posedge clk) trip[0] <= 1'h0;
    wr(TAMPER_ONE_CONFIG_ADDR, 8'h00);
    @(posedge clk) clr_int <= 1'h1;
    wr(TAMPER_TWO_CONFIG_ADDR, mk(1'h1, 2'h3, 1'h0, 2'h1));
    @(posedge clk) trip[1] <= 1'h1;
    repeat (12) @(posedge clk);
    rd(EVENT_FLAGS_ADDR, d);
    check("clear interval", d, 8'h00);
    @(posedge clk) clr_int <= 1'h0;
    wait_for(1'b0);
    @(posedge clk) rout <= 1'h1;
    @(posedge clk) rout <= 1'h0;
    @(negedge clk);
    check("irq reset out", 8'(irq_n), 8'h01);
    check("ext clear", 8'(ext_clr), 8'h01);
    @(posedge clk) trip[1] <= 1'h0;
    wr(TAMPER_TWO_CONFIG_ADDR, 8'h00);
    $display("test sampling done");
    rv = 8'(rnd());
    @(posedge clk) lv <= 2'h0;
    @(posedge clk);
    ram_addr <= rv[6:0];
    ram_wdata <= ~rv;
    ram_wr <= 1'h1;
    @(posedge clk) ram_wr <= 1'h0;
    @(posedge clk);
    @(negedge clk);
    check("ram data", ram_rdata, ~rv);
    wr(TAMPER_TWO_CONFIG_ADDR, 8'h84);
    wr(TAMPER_ONE_CONFIG_ADDR, mk(1'h0, 2'h2, 1'h0, 2'h2) | 8'h04);
    @(posedge clk) trip[0] <= 1'h1;
    wait_for(1'b1);
    check("pull one", 8'(p1), 8'h00);
    check("pull two", 8'(p2), 8'h03);
    repeat (140) @(posedge clk);
    @(negedge clk);
    check("ram blank", ram_rdata, RAM_INVALID_DATA);
    @(posedge clk) trip[0] <= 1'h0;
    wr(TAMPER_ONE_CONFIG_ADDR, 8'h00);
    wr(TAMPER_TWO_CONFIG_ADDR, 8'h00);
    repeat (3) @(posedge clk);
    @(negedge clk);
    check("ram cleared", ram_rdata, 8'h00);
    check("ram valid", 8'(ram_invalid), 8'h00);
    $display("test ram done");
    complete_run();
  end
endmodule : tb
